// File: verilog/tsh_pkg.sv
// Shared constants, types and helpers for the select and halt handler.
package tsh_pkg;

  // ===========================================================================
  // Command codes and frame lengths
  // ===========================================================================
  localparam logic [7:0] CMD_SELECT   = 8'h1d;
  localparam logic [7:0] CMD_HALT     = 8'h50;
  localparam logic [7:0] HALT_ANSWER  = 8'h00;
  localparam logic [3:0] SELECT_LEN   = 4'hb;
  localparam logic [3:0] HALT_LEN     = 4'h7;
  localparam logic [3:0] LEN_MAX      = 4'hf;

  // Byte positions inside a received frame.
  localparam logic [3:0] POS_CMD      = 4'h0;
  localparam logic [3:0] POS_UID0     = 4'h1;
  localparam logic [3:0] POS_UID1     = 4'h2;
  localparam logic [3:0] POS_UID2     = 4'h3;
  localparam logic [3:0] POS_UID3     = 4'h4;
  localparam logic [3:0] POS_PARAM4   = 4'h8;

  // ===========================================================================
  // Card number field
  // ===========================================================================
  localparam int         CID_LSB         = 4;
  localparam int         CID_W           = 4;
  localparam logic [3:0] CID_UNSUPPORTED = 4'hf;
  localparam logic [3:0] CID_ZERO        = 4'h0;
  localparam logic [3:0] CID_RESET       = 4'h0;
  localparam logic [3:0] RESP_LOW_NIB    = 4'h0;

  // Active command codes that are recognised, one bit per low nibble.
  localparam logic [15:0] ACT_CMD_MASK   = 16'h1f5e;

  // ===========================================================================
  // Type B CRC
  // ===========================================================================
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE    = 16'hf0b8;

  // Transmit byte indices.
  localparam logic [1:0] TX_DATA         = 2'h0;
  localparam logic [1:0] TX_CRC_LO       = 2'h1;
  localparam logic [1:0] TX_CRC_HI       = 2'h2;

  // Card states.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_READY  = 4'b0010,
    ST_ACTIVE = 4'b0100,
    ST_HALT   = 4'b1000
  } tsh_state_t;

  // One received frame as handed from the link side to the core side.
  typedef struct packed {
    logic [7:0]  cmd;
    logic [31:0] uid;
    logic [7:0]  param4;
    logic [3:0]  len;
    logic        good;
  } tsh_frame_t;

  // Tells whether a card-number nibble is legal for the variant.
  function automatic logic cid_valid(input logic [3:0] nib,
                                     input logic       second);
    cid_valid = (nib != CID_UNSUPPORTED) && (second || (nib != CID_ZERO));
  endfunction

endpackage

// File: verilog/tsh_crc16.sv
// Byte-wide Type B CRC register with clear and enable.
`timescale 1ns/1ps
module tsh_crc16 (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clear_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  data_i,
  output logic      [15:0] crc_next_o,
  output logic      [15:0] crc_o
);

  // ===========================================================================
  // Next value
  // ===========================================================================
  // Shifts the byte in least significant bit first, reflected polynomial.
  always_comb begin
    logic [15:0] c;
    c = crc_o ^ {8'h00, data_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ tsh_pkg::CRC_POLY) : (c >> 1);
    end
    crc_next_o = c;
  end

  // ===========================================================================
  // State
  // ===========================================================================
  // Clear wins over enable so a new frame always starts from the preset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clear_i) begin
      crc_o <= tsh_pkg::CRC_INIT;
    end else if (en_i) begin
      crc_o <= crc_next_o;
    end
  end

endmodule // tsh_crc16

// File: verilog/tsh_core.sv
// Card-side select and halt command handling with link crossing.
//
// Summary of operation
// RQ1: Select frame is 1D, identifier, four params, CRC.
// RQ2: Matching select after poll answer activates, latches number.
// RQ3: Active or halted card ignores select silently.
// RQ4: Select parameter bytes one to three are ignored.
// RQ5: Reader puts buffer size in parameter two.
// RQ6: Card number sits in upper nibble of parameter four.
// RQ7: First variant accepts card numbers 1 to 14.
// RQ8: Second variant accepts card numbers 0 to 14.
// RQ9: Nibble fifteen is refused in both variants.
// RQ10: Select answer is number nibble, zero nibble, CRC.
// RQ11: Corrupted select is dropped without any change.
// RQ12: Reader gives each active card a unique number.
// RQ13: Active card takes commands carrying its own number.
// RQ14: Halt frame is 50, identifier, CRC.
// RQ15: Matching halt after poll answer enters halt.
// RQ16: Halted card answers only the wake-up poll.
// RQ17: Active or halted card ignores halt silently.
// RQ18: Halt answer is byte 00 then CRC.
// RQ19: Corrupted halt is dropped without any change.
// RQ20: Select and halt honoured only after poll answer.
// RQ21: Active card ignores foreign numbers and bad codes.
// RQ22: Type B CRC checked on receive, sent on answer.
// RQ23: Identifier mismatch gives no answer, no change.
`timescale 1ns/1ps
module tsh_core #(
  parameter bit CID_VARIANT_SECOND = 1'b0
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        link_rst_n_i,
  input  wire logic [31:0] uid_i,
  input  wire logic        atqb_sent_i,
  input  wire logic        rx_sof_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_err_i,
  input  wire logic        tx_ready_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_last_o,
  output logic             active_o,
  output logic             halted_o,
  output logic      [3:0]  cid_o,
  output logic             cmd_strobe_o,
  output logic      [3:0]  cmd_code_o
);

  // ===========================================================================
  // Link side receive
  // ===========================================================================
  logic [3:0]          len_reg;
  logic                bad_reg;
  logic [7:0]          cmd_reg;
  logic [31:0]         uid_reg;
  logic [7:0]          param4_reg;
  tsh_pkg::tsh_frame_t frame_reg;
  logic                req_tgl_reg;
  logic [15:0]         rx_crc;
  logic [15:0]         rx_crc_next;

  // Receive CRC runs over every byte including the two check bytes.
  tsh_crc16 u_rx_crc (
    .clk_i      (link_clk_i),
    .rst_n_i    (link_rst_n_i),
    .clear_i    (rx_sof_i),
    .en_i       (rx_valid_i),
    .data_i     (rx_data_i),
    .crc_next_o (rx_crc_next),
    .crc_o      (rx_crc)
  );

  // Counts bytes and marks framing errors within the current frame.
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i || rx_sof_i) begin
      len_reg <= 4'h0;
      bad_reg <= 1'b0;
    end else begin
      if (rx_valid_i && (len_reg != tsh_pkg::LEN_MAX)) begin
        len_reg <= len_reg + 4'h1;
      end
      if (rx_err_i) begin
        bad_reg <= 1'b1;
      end
    end
  end

  // Keeps the bytes that carry meaning; parameters one to three drop out.
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      cmd_reg    <= 8'h00;
      uid_reg    <= 32'h0000_0000;
      param4_reg <= 8'h00;
    end else if (rx_valid_i) begin // RQ4
      unique case (len_reg)
        tsh_pkg::POS_CMD:    cmd_reg         <= rx_data_i;
        tsh_pkg::POS_UID0:   uid_reg[7:0]    <= rx_data_i;
        tsh_pkg::POS_UID1:   uid_reg[15:8]   <= rx_data_i;
        tsh_pkg::POS_UID2:   uid_reg[23:16]  <= rx_data_i;
        tsh_pkg::POS_UID3:   uid_reg[31:24]  <= rx_data_i;
        tsh_pkg::POS_PARAM4: param4_reg      <= rx_data_i;
        default: ;
      endcase
    end
  end

  // Publishes the finished frame and flips the request toggle.
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      frame_reg   <= '0;
      req_tgl_reg <= 1'b0;
    end else if (rx_eof_i) begin
      frame_reg.cmd    <= cmd_reg;
      frame_reg.uid    <= uid_reg;
      frame_reg.param4 <= param4_reg;
      frame_reg.len    <= len_reg;
      frame_reg.good   <= !bad_reg && !rx_err_i &&
                          (rx_crc == tsh_pkg::CRC_RESIDUE); // RQ22
      req_tgl_reg      <= ~req_tgl_reg;
    end
  end

  // ===========================================================================
  // Core side frame crossing
  // ===========================================================================
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_seen_reg;
  logic new_frame;

  // Two-stage synchroniser plus a history stage for edge detection.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
      req_seen_reg <= 1'b0;
    end else begin
      req_meta_reg <= req_tgl_reg;
      req_sync_reg <= req_meta_reg;
      req_seen_reg <= req_sync_reg;
    end
  end

  // The frame record is stable for a whole frame after the toggle flips.
  assign new_frame = req_sync_reg ^ req_seen_reg;

  // ===========================================================================
  // Core side decode
  // ===========================================================================
  tsh_pkg::tsh_state_t state_reg;
  tsh_pkg::tsh_state_t state_next;
  logic [3:0]          cid_reg;
  logic [3:0]          nib;
  logic                uid_ok;
  logic                sel_hit;
  logic                halt_hit;
  logic                act_hit;

  assign nib = frame_reg.param4[tsh_pkg::CID_LSB +: tsh_pkg::CID_W]; // RQ6
  assign uid_ok = (frame_reg.uid == uid_i); // RQ23

  // Frame classification; a bad frame matches nothing.
  assign sel_hit = new_frame && frame_reg.good && uid_ok &&
                   (frame_reg.cmd == tsh_pkg::CMD_SELECT) &&
                   (frame_reg.len == tsh_pkg::SELECT_LEN) &&
                   tsh_pkg::cid_valid(nib, CID_VARIANT_SECOND); // RQ1 RQ7 RQ8 RQ9 RQ11
  assign halt_hit = new_frame && frame_reg.good && uid_ok &&
                    (frame_reg.cmd == tsh_pkg::CMD_HALT) &&
                    (frame_reg.len == tsh_pkg::HALT_LEN); // RQ14 RQ19
  assign act_hit = new_frame && frame_reg.good &&
                   (frame_reg.len != 4'h0) &&
                   (frame_reg.cmd[7:4] == cid_reg) &&
                   tsh_pkg::ACT_CMD_MASK[frame_reg.cmd[3:0]]; // RQ13 RQ21

  // Next card state; only a ready card honours select or halt.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tsh_pkg::ST_IDLE: begin
        if (atqb_sent_i) state_next = tsh_pkg::ST_READY; // RQ20
      end
      tsh_pkg::ST_READY: begin
        if (sel_hit) begin
          state_next = tsh_pkg::ST_ACTIVE; // RQ2
        end else if (halt_hit) begin
          state_next = tsh_pkg::ST_HALT; // RQ15
        end
      end
      tsh_pkg::ST_ACTIVE: state_next = tsh_pkg::ST_ACTIVE; // RQ3 RQ17
      tsh_pkg::ST_HALT: begin
        if (atqb_sent_i) state_next = tsh_pkg::ST_READY; // RQ16
      end
    endcase
  end

  // Card state register.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= tsh_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latches the card number on a successful select only.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cid_reg <= tsh_pkg::CID_RESET;
    end else if ((state_reg == tsh_pkg::ST_READY) && sel_hit) begin
      cid_reg <= nib; // RQ2
    end
  end

  // Passes addressed active commands to the command executor.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cmd_strobe_o <= 1'b0;
      cmd_code_o   <= 4'h0;
    end else begin
      cmd_strobe_o <= (state_reg == tsh_pkg::ST_ACTIVE) && act_hit; // RQ13
      if ((state_reg == tsh_pkg::ST_ACTIVE) && act_hit) begin
        cmd_code_o <= frame_reg.cmd[3:0];
      end
    end
  end

  assign active_o = (state_reg == tsh_pkg::ST_ACTIVE);
  assign halted_o = (state_reg == tsh_pkg::ST_HALT); // RQ16
  assign cid_o    = cid_reg;

  // ===========================================================================
  // Core side answer request
  // ===========================================================================
  logic [7:0] resp_byte_reg;
  logic       resp_tgl_reg;

  // Holds the answer byte and flips the toggle toward the link side.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      resp_byte_reg <= 8'h00;
      resp_tgl_reg  <= 1'b0;
    end else if (state_reg == tsh_pkg::ST_READY) begin
      if (sel_hit) begin
        resp_byte_reg <= {nib, tsh_pkg::RESP_LOW_NIB}; // RQ10
        resp_tgl_reg  <= ~resp_tgl_reg;
      end else if (halt_hit) begin
        resp_byte_reg <= tsh_pkg::HALT_ANSWER; // RQ18
        resp_tgl_reg  <= ~resp_tgl_reg;
      end
    end
  end

  // ===========================================================================
  // Link side transmit
  // ===========================================================================
  logic       resp_meta_reg;
  logic       resp_sync_reg;
  logic       resp_seen_reg;
  logic [1:0] tx_idx_reg;
  logic       tx_load;
  logic       tx_fire;
  logic [15:0] tx_crc;
  logic [15:0] tx_crc_next;

  assign tx_load = (resp_sync_reg ^ resp_seen_reg) && !tx_valid_o;
  assign tx_fire = tx_valid_o && tx_ready_i;

  // Synchronises the answer toggle; a busy sender defers the take.
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      resp_meta_reg <= 1'b0;
      resp_sync_reg <= 1'b0;
      resp_seen_reg <= 1'b0;
    end else begin
      resp_meta_reg <= resp_tgl_reg;
      resp_sync_reg <= resp_meta_reg;
      if (tx_load) begin
        resp_seen_reg <= resp_sync_reg;
      end
    end
  end

  // Transmit CRC covers the answer byte only.
  tsh_crc16 u_tx_crc (
    .clk_i      (link_clk_i),
    .rst_n_i    (link_rst_n_i),
    .clear_i    (tx_load),
    .en_i       (tx_fire && (tx_idx_reg == tsh_pkg::TX_DATA)),
    .data_i     (tx_data_o),
    .crc_next_o (tx_crc_next),
    .crc_o      (tx_crc)
  );

  // Sends answer byte, then the complemented CRC low byte first.
  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      tx_idx_reg <= tsh_pkg::TX_DATA;
    end else if (tx_load) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= resp_byte_reg;
      tx_idx_reg <= tsh_pkg::TX_DATA;
    end else if (tx_fire) begin
      unique case (tx_idx_reg)
        tsh_pkg::TX_DATA: begin
          tx_data_o  <= ~tx_crc_next[7:0]; // RQ22
          tx_idx_reg <= tsh_pkg::TX_CRC_LO;
        end
        tsh_pkg::TX_CRC_LO: begin
          tx_data_o  <= ~tx_crc[15:8]; // RQ22
          tx_idx_reg <= tsh_pkg::TX_CRC_HI;
        end
        default: begin
          tx_valid_o <= 1'b0;
          tx_idx_reg <= tsh_pkg::TX_DATA;
        end
      endcase
    end
  end

  assign tx_last_o = tx_valid_o && (tx_idx_reg == tsh_pkg::TX_CRC_HI);

  // ===========================================================================
  // Assertions
  // ===========================================================================
  AST_SEL_ACTIVE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == tsh_pkg::ST_READY) && sel_hit |=>
      (state_reg == tsh_pkg::ST_ACTIVE) && (cid_reg == $past(nib))) // RQ2
    else $error("Select did not activate the card.");

  AST_SEL_ANSWER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == tsh_pkg::ST_READY) && sel_hit |=>
      (resp_byte_reg == {cid_reg, 4'h0}) && (resp_tgl_reg != $past(resp_tgl_reg))) // RQ10
    else $error("Select answer byte is wrong.");

  AST_NO_ANSWER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg inside {tsh_pkg::ST_ACTIVE, tsh_pkg::ST_HALT}) |=>
      $stable(resp_tgl_reg)) // RQ3
    else $error("Active or halted card answered.");

  AST_BAD_FRAME: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_frame && !frame_reg.good && !atqb_sent_i |=>
      $stable(state_reg) && $stable(cid_reg) && $stable(resp_tgl_reg)) // RQ11
    else $error("Corrupted frame changed the card.");

  AST_HALT_ENTRY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == tsh_pkg::ST_READY) && halt_hit && !sel_hit |=>
      (state_reg == tsh_pkg::ST_HALT) && (resp_byte_reg == 8'h00)) // RQ18
    else $error("Halt frame was not honoured.");

  AST_HALT_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == tsh_pkg::ST_HALT) && !atqb_sent_i |=>
      (state_reg == tsh_pkg::ST_HALT)) // RQ16
    else $error("Halted card left halt without a wake-up.");

  AST_UID_MISMATCH: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == tsh_pkg::ST_READY) && new_frame && !uid_ok |=>
      (state_reg == tsh_pkg::ST_READY) && $stable(resp_tgl_reg)) // RQ23
    else $error("Foreign identifier changed the card.");

  AST_CMD_FILTER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cmd_strobe_o |-> $past(active_o) &&
      ($past(frame_reg.cmd[7:4]) == cid_reg)) // RQ13
    else $error("Command passed with a foreign card number.");

  AST_CID_LEGAL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    active_o |-> tsh_pkg::cid_valid(cid_reg, CID_VARIANT_SECOND)) // RQ7
    else $error("Active card holds an illegal card number.");

  AST_TX_LENGTH: assert property (@(posedge link_clk_i) disable iff (!link_rst_n_i)
    tx_fire && tx_last_o |=> !tx_valid_o) // RQ10
    else $error("Answer ran past three bytes.");

endmodule // tsh_core

// File: dv/tsh_reader.sv
// Behavioural reader model that frames commands and takes answers.
`timescale 1ns/1ps
module tsh_reader (
  input  wire logic       link_clk_i,
  input  wire logic       slow_i,
  output logic            rx_sof_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_eof_o,
  output logic            rx_err_o,
  output logic            tx_ready_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i
);
  logic [1:0] ph_reg = 2'h0;

  initial begin
    rx_sof_o   = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'ha5;
    rx_eof_o   = 1'b0;
    rx_err_o   = 1'b0;
    tx_ready_o = 1'b1;
  end

  // ==========================================================================
  // Answer sink
  // ==========================================================================
  // The sink stalls every other cycle when asked to be slow.
  always @(posedge link_clk_i) begin
    ph_reg     <= ph_reg + 2'h1;
    tx_ready_o <= !slow_i || ph_reg[0];
  end

  // Type B CRC register over a byte queue, before complement.
  function automatic logic [15:0] crcb(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Sends one frame; the data line shows the inverse of the last byte
  // outside the frame so that a stale byte is never mistaken for data.
  task automatic send(input logic [7:0] body[$], input bit bad_crc,
                      input bit code_err);
    logic [15:0] c;
    c = ~crcb(body);
    body.push_back(c[7:0]);
    body.push_back(c[15:8] ^ {7'h00, bad_crc});
    @(posedge link_clk_i);
    rx_sof_o <= 1'b1;
    foreach (body[i]) begin
      @(posedge link_clk_i);
      rx_sof_o   <= 1'b0;
      rx_valid_o <= 1'b1;
      rx_data_o  <= body[i];
      rx_err_o   <= code_err && (i == 2);
    end
    @(posedge link_clk_i);
    rx_valid_o <= 1'b0;
    rx_err_o   <= 1'b0;
    rx_eof_o   <= 1'b1;
    rx_data_o  <= ~body[body.size() - 1];
    @(posedge link_clk_i);
    rx_eof_o <= 1'b0;
  endtask

  // Gathers answer bytes for long enough to cover the reply delay.
  task automatic collect(output logic [7:0] got[$], output logic [7:0] lp);
    got = {};
    lp  = 8'hff;
    repeat (60) begin
      @(posedge link_clk_i);
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
        if (tx_last_i === 1'b1) lp = 8'(got.size());
        got.push_back(tx_data_i);
      end
    end
  endtask
endmodule // tsh_reader

// File: dv/tb.sv
// Self-checking bench for the select and halt handler.
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] UID    = 32'h8a3c5e71;
  localparam logic [15:0] ACT_OK = 16'h1f5e;
  logic       core_clk_i = 1'b0;
  logic       link_clk   = 1'b0;
  logic       rst_n      = 1'b0;
  logic       link_rst_n = 1'b0;
  logic       atqb       = 1'b0;
  logic       slow       = 1'b0;
  logic       sof, vld, eof, rerr, rdy, txv, txl, act, hlt, stb;
  logic [7:0] rxd, txd;
  logic [3:0] cid, code;
  logic [3:0] stb_code = 4'h0;
  logic [7:0] fr[$];
  logic [7:0] u[$];
  int         err_count    = 0;
  int         total_checks = 0;
  int         stb_n        = 0;
  int         exp_n        = 0;
  int         cyc          = 0;

  // Core clock at 40 MHz and an unrelated 15 ns link clock.
  always #12.5 core_clk_i = ~core_clk_i;
  always #7.5 link_clk = ~link_clk;

  tsh_core #(.CID_VARIANT_SECOND(1'b0)) dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n), .link_clk_i(link_clk),
    .link_rst_n_i(link_rst_n), .uid_i(UID), .atqb_sent_i(atqb),
    .rx_sof_i(sof), .rx_valid_i(vld), .rx_data_i(rxd), .rx_eof_i(eof),
    .rx_err_i(rerr), .tx_ready_i(rdy), .tx_valid_o(txv),
    .tx_data_o(txd), .tx_last_o(txl), .active_o(act), .halted_o(hlt),
    .cid_o(cid), .cmd_strobe_o(stb), .cmd_code_o(code));

  tsh_reader rd_u (
    .link_clk_i(link_clk), .slow_i(slow), .rx_sof_o(sof),
    .rx_valid_o(vld), .rx_data_o(rxd), .rx_eof_o(eof), .rx_err_o(rerr),
    .tx_ready_o(rdy), .tx_valid_i(txv), .tx_data_i(txd),
    .tx_last_i(txl));

  // Counts command strobes and keeps the last code; also cuts a hang.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (stb === 1'b1) begin
      stb_n    <= stb_n + 1;
      stb_code <= code;
    end
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Sends the frame in fr and checks for an answer led by byte b0.
  task automatic frame(input bit bad, input bit cerr, input bit ans,
                       input logic [7:0] b0);
    logic [7:0]  got[$];
    logic [7:0]  lp;
    logic [15:0] c;
    rd_u.send(fr, bad, cerr);
    rd_u.collect(got, lp);
    chk("answer length", ans ? 16'h0003 : 16'h0000, 16'(got.size()));
    if (ans && got.size() == 3) begin
      c = ~rd_u.crcb({b0});
      chk("answer byte", {8'h00, b0}, {8'h00, got[0]});
      chk("answer crc", c, {got[2], got[1]});
      chk("last index", 16'h0002, {8'h00, lp});
    end
  endtask

  task automatic st(input logic a, input logic h, input logic [3:0] c);
    chk("state", {8'h00, a, h, 2'b00, c}, {8'h00, act, hlt, 2'b00, cid});
  endtask

  task automatic sel(input logic [7:0] p2, input logic [7:0] p4);
    fr = {8'h1d, u, 8'hff, p2, 8'h5a, p4};
  endtask

  task automatic poll();
    @(posedge core_clk_i);
    atqb <= 1'b1;
    @(posedge core_clk_i);
    atqb <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    u = {UID[7:0], UID[15:8], UID[23:16], UID[31:24]};
    repeat (3) @(posedge core_clk_i);
    rst_n <= 1'b1;
    @(posedge link_clk);
    link_rst_n <= 1'b1;
    st(1'b0, 1'b0, 4'h0);
    sel(8'h00, 8'h50);
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    $display("test no poll done");
    poll();
    fr = {8'h1d, 8'h70, u[1], u[2], u[3], 8'h00, 8'h00, 8'h00, 8'h50};
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    sel(8'h05, 8'h50);
    frame(1'b1, 1'b0, 1'b0, 8'h00);
    fr = {8'h50, u};
    frame(1'b0, 1'b1, 1'b0, 8'h00);
    sel(8'h00, 8'h00);
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    sel(8'h00, 8'hf0);
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    st(1'b0, 1'b0, 4'h0);
    $display("test refusals done");
    slow <= 1'b1;
    fr = {8'h50, u};
    frame(1'b0, 1'b0, 1'b1, 8'h00);
    st(1'b0, 1'b1, 4'h0);
    sel(8'h00, 8'h30);
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    fr = {8'h50, u};
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    st(1'b0, 1'b1, 4'h0);
    $display("test halt done");
    poll();
    sel(8'h0f, 8'he0);
    frame(1'b0, 1'b0, 1'b1, 8'he0);
    st(1'b1, 1'b0, 4'he);
    sel(8'h00, 8'h30);
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    fr = {8'h50, u};
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    st(1'b1, 1'b0, 4'he);
    $display("test select done");
    slow <= 1'b0;
    for (int n = 0; n < 16; n++) begin
      fr = {8'he0 | 8'(n)};
      frame(1'b0, 1'b0, 1'b0, 8'h00);
      exp_n += int'(ACT_OK[n]);
      chk("strobes", 16'(exp_n), 16'(stb_n));
      if (ACT_OK[n]) chk("code", 16'(n), {12'h000, stb_code});
    end
    fr = {8'h52};
    frame(1'b0, 1'b0, 1'b0, 8'h00);
    chk("strobes", 16'(exp_n), 16'(stb_n));
    $display("test active commands done");
    tally_and_finish();
  end
endmodule // tb
